// ===== mms_pkg.sv
// Constants for the mode and system control register bank.
// Assumes one 10 MHz clock and an AXI4-Lite master with 32-bit data.
//
// Behaviour
// [RQ1] Pins 01 give mode 1, 10 mode 2, 11 mode 3; 00 unused.
// [RQ2] Board selects only modes 1 to 3 and never changes the pins.
// [RQ3] External data bus is 8 bits wide in every expanded mode.
// [RQ4] 16 address outputs; advanced external use only single-chip or with strobe.
// [RQ5] Modes 2 and 3 start single-chip; expand only once software sets enable.
// [RQ6] Four registers decoded by low 16 bits at consecutive locations.
// [RQ7] Expanded enable fixed at 1 in mode 1; else resets 0, writable.
// [RQ8] Expanded enable 0 means single-chip, 1 means expanded.
// [RQ9] Reset and hardware standby set expanded enable from the mode.
// [RQ10] Mode register bits 6 to 2 read zero and ignore writes.
// [RQ11] Mode status bits are read-only, pin levels caught on each read.
// [RQ12] System control resets to 09 hex, also in hardware standby.
// [RQ13] Strobe select 0 gives address strobe, 1 gives ranged I/O strobe.
// [RQ14] Reset source flag read-only: external reset sets, watchdog clears.
// [RQ15] Host window select steers two address windows to timer or host.
// [RQ16] RAM enable 0 disables, 1 enables; set to 1 when reset ends.
// [RQ17] Chip select location bit picks the pin of chip select two.
// [RQ18] Reset flag and upper interrupt mode bit read-only; rest read-write.
// [RQ19] Bus control resets to d7 hex, serial timer control to 00.
// [RQ20] Byte-wide accesses; writes leave read-only fields unchanged.

package mms_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [15:0] MMS_IDX_SERIAL_TIMER = 16'hffc3;
  localparam logic [15:0] MMS_IDX_SYSTEM = 16'hffc4;
  localparam logic [15:0] MMS_IDX_MODE = 16'hffc5;
  localparam logic [15:0] MMS_IDX_BUS = 16'hffc6;

  // Reset values
  localparam logic [7:0] MMS_RST_SERIAL_TIMER = 8'h00;
  localparam logic [7:0] MMS_RST_SYSTEM = 8'h09;
  localparam logic [7:0] MMS_RST_BUS = 8'hd7;

  // Mode register fields
  localparam int MMS_MODE_EXPANDED_ENABLE_BIT = 7;
  localparam int MMS_MODE_STAT_HI_BIT = 1;
  localparam int MMS_MODE_STAT_LO_BIT = 0;

  // System control fields
  localparam int MMS_SYS_CS_LOC_BIT = 7;
  localparam int MMS_SYS_IO_STROBE_SELECT_BIT = 6;
  localparam int MMS_SYS_INTM_HI_BIT = 5;
  localparam int MMS_SYS_RESET_SOURCE_FLAG_BIT = 3;
  localparam int MMS_SYS_HIE_BIT = 1;
  localparam int MMS_SYS_RAM_ENABLE_BIT_BIT = 0;
  // Bits 5 and 3 are not writable
  localparam logic [7:0] MMS_SYS_WR_MASK = 8'hd7;

  // Bus control strobe range field
  localparam int MMS_BUS_IOS_LSB = 0;

  // I/O strobe ranges, all from one base
  localparam logic [15:0] MMS_IOS_BASE = 16'hf000;
  localparam logic [15:0] MMS_IOS_END0 = 16'hf03f;
  localparam logic [15:0] MMS_IOS_END1 = 16'hf0ff;
  localparam logic [15:0] MMS_IOS_END2 = 16'hf3ff;
  localparam logic [15:0] MMS_IOS_END3 = 16'hfe4f;

  // Host or timer windows
  localparam logic [15:0] MMS_WIN0_LO = 16'hfff0;
  localparam logic [15:0] MMS_WIN0_HI = 16'hfff7;
  localparam logic [15:0] MMS_WIN1_LO = 16'hfffc;

  // External bus shape
  localparam int MMS_EXT_DATA_W = 8;
  localparam int MMS_EXT_ADDR_PINS = 16;

  // AXI responses
  localparam logic [1:0] MMS_RESP_OKAY = 2'b00;
  localparam logic [1:0] MMS_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MMS_MODE_NONE,
    MMS_MODE_1,
    MMS_MODE_2,
    MMS_MODE_3
  } mms_mode_t;

endpackage : mms_pkg

// ===== mms_top.sv
// Mode selection and system control register bank with AXI4-Lite slave.
// Assumes mode pins and the standby pin are asynchronous, the watchdog
// reset and CPU address inputs come from logic on aclk.
//
// The AXI4-Lite register port was left to the implementer.

`timescale 1ns/1ps

module mms_top
  import mms_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_pin_high,
  input wire logic mode_pin_low,
  input wire logic hw_standby_n,
  input wire logic wdt_overflow_reset,
  input wire logic cpu_access_valid,
  input wire logic cpu_access_ext,
  input wire logic [15:0] cpu_addr,
  output logic cpu_advanced_mode,
  output logic rom_enable,
  output logic expanded_active,
  output logic [3:0] ext_data_width,
  output logic [4:0] ext_addr_pins,
  output logic adv_ext_addr_ok,
  output logic shared_strobe_pin_n,
  output logic host_window_to_host,
  output logic host_window_to_timer,
  output logic ram_enable,
  output logic chip_select_location,
  output logic [7:0] serial_timer_control_q,
  output logic [7:0] bus_control_q
);

  // Index needs address bits 17 to 2
  if (ADDR_W < 18) begin : g_chk
    $error("mms_top: ADDR_W must be at least 18");
  end

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers and init
  ////////////////////////////////////////////////////////////////////////

  logic [1:0] mode_s1_reg;
  logic [1:0] mode_s2_reg;
  logic stby_s1_reg;
  logic stby_s2_reg;
  logic init_regs;
  logic init_wdt;

  // Two flops per pin; first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_s1_reg <= 2'h0;
      mode_s2_reg <= 2'h0;
      stby_s1_reg <= 1'b1;
      stby_s2_reg <= 1'b1;
    end else begin
      mode_s1_reg <= {mode_pin_high, mode_pin_low};
      mode_s2_reg <= mode_s1_reg;
      stby_s1_reg <= hw_standby_n;
      stby_s2_reg <= stby_s1_reg;
    end
  end

  // Reset, standby or watchdog all reload the registers; the bus
  // handshake state is reset only by aresetn, so a reload never strands
  // a transfer that is under way
  assign init_wdt = wdt_overflow_reset;
  assign init_regs = !aresetn || !stby_s2_reg || init_wdt;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  ////////////////////////////////////////////////////////////////////////

  mms_mode_t mode;

  // Pattern 00 is unused; it falls to the no-mode state
  // Board must never select it; no-mode keeps ROM and advanced
  // addressing off as the safe choice
  always_comb begin
    unique case (mode_s2_reg)
      2'b01: mode = MMS_MODE_1; // RQ1
      2'b10: mode = MMS_MODE_2; // RQ1
      2'b11: mode = MMS_MODE_3; // RQ1
      2'b00: mode = MMS_MODE_NONE; // RQ2
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  ////////////////////////////////////////////////////////////////////////

  logic aw_full_reg;
  logic w_full_reg;
  logic [15:0] aw_idx_reg;
  logic [7:0] w_byte_reg;
  logic w_lane0_reg;
  logic wr_fire;
  logic aw_take;
  logic w_take;
  logic wr_hit;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_full_reg && w_full_reg;

  // Decode on the low 16 bits of the word index
  assign wr_hit = (aw_idx_reg == MMS_IDX_SERIAL_TIMER) ||
                  (aw_idx_reg == MMS_IDX_SYSTEM) ||
                  (aw_idx_reg == MMS_IDX_MODE) ||
                  (aw_idx_reg == MMS_IDX_BUS); // RQ6

  // Address and data are held apart, so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= 16'h0000;
      w_byte_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MMS_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[17:2];
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        w_byte_reg <= s_axi_wdata[7:0]; // RQ20
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? MMS_RESP_OKAY : MMS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Ready only while idle; one write at a time
      s_axi_awready <= !aw_full_reg && !aw_take && !wr_fire &&
                       !s_axi_bvalid;
      s_axi_wready <= !w_full_reg && !w_take && !wr_fire &&
                      !s_axi_bvalid;
    end
  end

  logic wr_stc;
  logic wr_sys;
  logic wr_mode;
  logic wr_bus;

  // A write without byte lane 0 changes nothing
  assign wr_stc = wr_fire && w_lane0_reg &&
                  (aw_idx_reg == MMS_IDX_SERIAL_TIMER);
  assign wr_sys = wr_fire && w_lane0_reg && (aw_idx_reg == MMS_IDX_SYSTEM);
  assign wr_mode = wr_fire && w_lane0_reg && (aw_idx_reg == MMS_IDX_MODE);
  assign wr_bus = wr_fire && w_lane0_reg && (aw_idx_reg == MMS_IDX_BUS);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////////////

  logic [7:0] stc_reg;
  logic [7:0] sys_reg;
  logic [7:0] bus_reg;
  logic expanded_enable_reg;
  logic expanded_enable_eff;

  // Serial timer and bus control: plain byte registers
  always_ff @(posedge aclk) begin
    if (init_regs) begin
      stc_reg <= MMS_RST_SERIAL_TIMER; // RQ19
      bus_reg <= MMS_RST_BUS; // RQ19
    end else begin
      if (wr_stc) begin
        stc_reg <= w_byte_reg;
      end
      if (wr_bus) begin
        bus_reg <= w_byte_reg;
      end
    end
  end

  // System control; the watchdog reload clears the source flag
  always_ff @(posedge aclk) begin
    if (!aresetn || !stby_s2_reg) begin
      sys_reg <= MMS_RST_SYSTEM; // RQ12 RQ14 RQ16
    end else if (init_wdt) begin
      sys_reg <= MMS_RST_SYSTEM & ~(8'h01 << MMS_SYS_RESET_SOURCE_FLAG_BIT); // RQ14
    end else if (wr_sys) begin
      sys_reg <= (w_byte_reg & MMS_SYS_WR_MASK) |
                 (sys_reg & ~MMS_SYS_WR_MASK); // RQ18 RQ20
    end
  end

  // Expanded enable; read-only in mode 1 where it always shows 1
  always_ff @(posedge aclk) begin
    if (init_regs) begin
      expanded_enable_reg <= (mode == MMS_MODE_1); // RQ5 RQ9
    end else if (wr_mode && (mode != MMS_MODE_1)) begin
      expanded_enable_reg <= w_byte_reg[MMS_MODE_EXPANDED_ENABLE_BIT]; // RQ7
    end
  end

  assign expanded_enable_eff = expanded_enable_reg || (mode == MMS_MODE_1); // RQ7

  // No separate store for the mode status bits: the read data register
  // takes the synchronised pin levels at the edge that accepts a read of
  // the mode register, and that is the latch on read. A second copy here
  // would be read by nothing and could only drift from what software saw.
  // Trade-off: a read shows the pins as they were two clocks earlier,
  // which is harmless since the board never moves them while running.

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  ////////////////////////////////////////////////////////////////////////

  logic rd_take;
  logic [15:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;

  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[17:2];

  // Read mux; reserved mode bits are zero, pins read live
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (rd_idx)
      MMS_IDX_SERIAL_TIMER: rd_byte = stc_reg;
      MMS_IDX_SYSTEM: rd_byte = sys_reg;
      MMS_IDX_MODE: begin
        rd_byte[MMS_MODE_EXPANDED_ENABLE_BIT] = expanded_enable_eff; // RQ10
        rd_byte[MMS_MODE_STAT_HI_BIT] = mode_s2_reg[1]; // RQ11
        rd_byte[MMS_MODE_STAT_LO_BIT] = mode_s2_reg[0]; // RQ11
      end
      MMS_IDX_BUS: rd_byte = bus_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // One read at a time; data answers the cycle after the take
  // Ready drops for a cycle after each answer, so reads are spaced out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= MMS_RESP_OKAY;
    end else begin
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte}; // RQ20
        s_axi_rresp <= rd_hit ? MMS_RESP_OKAY : MMS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !rd_take && !s_axi_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobe and window steering
  ////////////////////////////////////////////////////////////////////////

  logic [15:0] ios_end;
  logic ios_hit;
  logic win_hit;
  logic io_strobe_select;
  logic host_window_select;

  assign io_strobe_select = sys_reg[MMS_SYS_IO_STROBE_SELECT_BIT];
  assign host_window_select = sys_reg[MMS_SYS_HIE_BIT];

  // Range end picked by the two strobe range bits
  always_comb begin
    unique case (bus_reg[MMS_BUS_IOS_LSB +: 2])
      2'b00: ios_end = MMS_IOS_END0;
      2'b01: ios_end = MMS_IOS_END1;
      2'b10: ios_end = MMS_IOS_END2;
      2'b11: ios_end = MMS_IOS_END3;
    endcase
  end

  assign ios_hit = (cpu_addr >= MMS_IOS_BASE) && (cpu_addr <= ios_end);
  // Second window runs to the top of the space
  assign win_hit = ((cpu_addr >= MMS_WIN0_LO) &&
                    (cpu_addr <= MMS_WIN0_HI)) ||
                   (cpu_addr >= MMS_WIN1_LO);

  // Strobe low only in expanded mode; registered so it is glitch free
  // Cost: the strobe lags the access by one clock
  always_ff @(posedge aclk) begin
    if (init_regs) begin
      shared_strobe_pin_n <= 1'b1;
    end else begin
      shared_strobe_pin_n <= !(expanded_enable_eff && cpu_access_ext &&
                               (!io_strobe_select || ios_hit)); // RQ13
    end
  end

  // Window steering follows the host window select
  // Both outputs stay low outside the two windows
  always_ff @(posedge aclk) begin
    if (init_regs) begin
      host_window_to_host <= 1'b0;
      host_window_to_timer <= 1'b0;
    end else begin
      host_window_to_host <= cpu_access_valid && win_hit && host_window_select; // RQ15
      host_window_to_timer <= cpu_access_valid && win_hit && !host_window_select; // RQ15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode and control outputs
  ////////////////////////////////////////////////////////////////////////

  // All control outputs lag their register by one clock
  // so every top-level output comes straight from a flop
  always_ff @(posedge aclk) begin
    if (init_regs) begin
      cpu_advanced_mode <= 1'b0;
      rom_enable <= 1'b0;
      expanded_active <= 1'b0;
      ext_data_width <= 4'h0;
      ext_addr_pins <= 5'h00;
      adv_ext_addr_ok <= 1'b0;
      ram_enable <= 1'b1;
      chip_select_location <= 1'b0;
      serial_timer_control_q <= MMS_RST_SERIAL_TIMER;
      bus_control_q <= MMS_RST_BUS;
    end else begin
      cpu_advanced_mode <= (mode == MMS_MODE_2); // RQ1
      rom_enable <= (mode == MMS_MODE_2) || (mode == MMS_MODE_3); // RQ1
      expanded_active <= expanded_enable_eff; // RQ5 RQ8
      ext_data_width <= 4'(MMS_EXT_DATA_W); // RQ3
      ext_addr_pins <= 5'(MMS_EXT_ADDR_PINS); // RQ4
      // Advanced addressing reaches outside only through the strobe
      adv_ext_addr_ok <= (mode == MMS_MODE_2) &&
                         (!expanded_enable_eff || io_strobe_select); // RQ4
      ram_enable <= sys_reg[MMS_SYS_RAM_ENABLE_BIT_BIT]; // RQ16
      chip_select_location <= sys_reg[MMS_SYS_CS_LOC_BIT]; // RQ17
      serial_timer_control_q <= stc_reg;
      bus_control_q <= bus_reg;
    end
  end

endmodule : mms_top

// ===== mms_board.sv
// Far-side model: board mode pins and the CPU's access strobes.
// Assumes requests from the bench change just after rising edges.
`timescale 1ns/1ps

module mms_board (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] mode_req,
  input wire logic acc_req,
  input wire logic acc_ext_req,
  input wire logic [15:0] acc_addr_req,
  output logic mode_pin_high,
  output logic mode_pin_low,
  output logic cpu_access_valid,
  output logic cpu_access_ext,
  output logic [15:0] cpu_addr
);
  // Pins move only while reset holds; never during operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {mode_pin_high, mode_pin_low} <= mode_req;
    end
  end

  // Idle address toggles so stale values never look valid
  always_ff @(posedge aclk) begin
    cpu_access_valid <= acc_req;
    cpu_access_ext <= acc_req && acc_ext_req;
    cpu_addr <= acc_req ? acc_addr_req : ~cpu_addr;
  end
endmodule : mms_board

// ===== mms_props.sv
// Checker for the bank's bus answers, strobe and window outputs.
// Assumes binding to mms_top; one clock, sync active-low reset.
`timescale 1ns/1ps

module mms_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic cpu_access_valid,
  input wire logic cpu_access_ext,
  input wire logic [15:0] cpu_addr,
  input wire logic expanded_active,
  input wire logic shared_strobe_pin_n,
  input wire logic host_window_to_host,
  input wire logic host_window_to_timer
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////
  // Bus answers hold until taken; only one byte is ever returned
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  rdata_byte_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("rdata upper bits set");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");

  ////////////////////////////////////////////////////////////////////////
  // Window steering and strobe lag their cause by one clock
  win_steer_a: assert property (cpu_access_valid && (cpu_addr inside
    {[16'hfff0:16'hfff7], [16'hfffc:16'hffff]}) |=>
    host_window_to_host || host_window_to_timer) else $error("no steer");
  win_idle_a: assert property (!cpu_access_valid |=>
    !host_window_to_host && !host_window_to_timer) else $error("stray win");
  win_excl_a: assert property (!(host_window_to_host &&
    host_window_to_timer)) else $error("both windows");
  strobe_idle_a: assert property (!cpu_access_ext |=>
    shared_strobe_pin_n) else $error("strobe without access");
  strobe_single_a: assert property (cpu_access_ext ##1 !expanded_active
    |-> shared_strobe_pin_n) else $error("strobe in single chip");

  // Main scenarios reached
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (host_window_to_host);
  cover property (!shared_strobe_pin_n);
endmodule : mms_props

bind mms_top mms_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .cpu_access_valid(cpu_access_valid), .cpu_access_ext(cpu_access_ext),
  .cpu_addr(cpu_addr), .expanded_active(expanded_active),
  .shared_strobe_pin_n(shared_strobe_pin_n),
  .host_window_to_host(host_window_to_host),
  .host_window_to_timer(host_window_to_timer));

// ===== mcu_mode_and_system_control_tb.sv
// Bench for the mode and system control bank over AXI4-Lite.
// Assumes mms_top, mms_board and the bound checker are compiled first.
`timescale 1ns/1ps

module mcu_mode_and_system_control_tb
  import mms_pkg::*;
;
  localparam logic [31:0] A_ST = {14'h0, MMS_IDX_SERIAL_TIMER, 2'b00};
  localparam logic [31:0] A_SYS = {14'h0, MMS_IDX_SYSTEM, 2'b00};
  localparam logic [31:0] A_MODE = {14'h0, MMS_IDX_MODE, 2'b00};
  localparam logic [31:0] A_BUS = {14'h0, MMS_IDX_BUS, 2'b00};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, wdt;
  logic hw_standby_n, acc_req, acc_ext, awready, wready, bvalid, arready;
  logic rvalid, mph, mpl, cav, cae, adv, rom, expa, aok, strobe_n;
  logic to_host, to_timer, ram, csl;
  logic [1:0] bresp, rresp, mode_req, r;
  logic [2:0] seen;
  logic [3:0] edw, wstrb;
  logic [4:0] eap;
  logic [7:0] stc, bcq;
  logic [15:0] acc_addr, cpu_addr;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  int n_mismatch, check_count, cyc;

  mms_board board (.aclk(aclk), .aresetn(aresetn), .mode_req(mode_req),
    .acc_req(acc_req), .acc_ext_req(acc_ext), .acc_addr_req(acc_addr),
    .mode_pin_high(mph), .mode_pin_low(mpl), .cpu_access_valid(cav),
    .cpu_access_ext(cae), .cpu_addr(cpu_addr));

  mms_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mode_pin_high(mph), .mode_pin_low(mpl), .hw_standby_n(hw_standby_n),
    .wdt_overflow_reset(wdt), .cpu_access_valid(cav),
    .cpu_access_ext(cae), .cpu_addr(cpu_addr), .cpu_advanced_mode(adv),
    .rom_enable(rom), .expanded_active(expa), .ext_data_width(edw),
    .ext_addr_pins(eap), .adv_ext_addr_ok(aok),
    .shared_strobe_pin_n(strobe_n), .host_window_to_host(to_host),
    .host_window_to_timer(to_timer), .ram_enable(ram),
    .chip_select_location(csl), .serial_timer_control_q(stc),
    .bus_control_q(bcq));

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks; checks wait for a settled half cycle
  task results;
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    @(negedge aclk);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  // Slow master: response ready only after valid is seen
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    logic ta, tw, tk, bv;
    tk = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!tk) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tk = bvalid && bready;
      bv = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= bv && !tk;
    end
  endtask : wr

  task automatic rd(input logic [31:0] a);
    logic ta, tk, rv;
    tk = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    while (!tk) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tk = rvalid && rready;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      rready <= rv && !tk;
    end
  endtask : rd

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
    chk(r, MMS_RESP_OKAY);
  endtask : rdc

  // One CPU access; gathers window and strobe activity it caused
  task automatic acc(input logic [15:0] a, input logic ext);
    @(posedge aclk);
    acc_addr <= a;
    acc_req <= 1'b1;
    acc_ext <= ext;
    @(posedge aclk);
    acc_req <= 1'b0;
    seen = 3'b000;
    repeat (3) begin
      @(negedge aclk);
      seen = seen | {to_host, to_timer, ~strobe_n};
    end
  endtask : acc

  task automatic reboot(input logic [1:0] m);
    @(posedge aclk);
    mode_req <= m;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : reboot

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_vals;
    rdc(A_ST, 32'h00);
    rdc(A_SYS, 32'h09);
    rdc(A_BUS, 32'hd7);
    rdc(A_MODE, 32'h03);
    chk({rom, adv, expa, ram}, 4'b1001);
    chk({edw, eap}, {4'h8, 5'h10});
    chk(bcq, 8'hd7);
  endtask : t_reset_vals

  task automatic t_sys;
    wr(A_SYS, 8'hff);
    rdc(A_SYS, 32'hdf);
    chk({ram, csl}, 2'b11);
    wr(A_SYS, 8'h00);
    rdc(A_SYS, 32'h08);
    chk({ram, csl}, 2'b00);
    wr(A_ST, 8'h5a);
    chk(stc, 8'h5a);
    @(posedge aclk);
    wstrb <= 4'h0;
    wr(A_ST, 8'ha5);
    wstrb <= 4'h1;
    chk(stc, 8'h5a);
    chk(r, MMS_RESP_OKAY);
    wr(A_BUS + 32'h4, 8'h55);
    chk(r, MMS_RESP_SLVERR);
    rd(A_BUS + 32'h4);
    chk(r, MMS_RESP_SLVERR);
  endtask : t_sys

  task automatic t_strobe;
    wr(A_MODE, 8'hff);
    rdc(A_MODE, 32'h83);
    acc(16'h1234, 1'b1);
    chk(seen[0], 1'b1);
    wr(A_SYS, 8'h40);
    wr(A_BUS, 8'hd4);
    acc(16'hf040, 1'b1);
    chk(seen[0], 1'b0);
    acc(16'hf03f, 1'b1);
    chk(seen[0], 1'b1);
    wr(A_MODE, 8'h00);
    acc(16'h1234, 1'b1);
    chk({seen[0], expa}, 2'b00);
  endtask : t_strobe

  task automatic t_window;
    wr(A_SYS, 8'h00);
    acc(16'hfff3, 1'b0);
    chk(seen[2:1], 2'b01);
    wr(A_SYS, 8'h02);
    acc(16'hffff, 1'b0);
    chk(seen[2:1], 2'b10);
    acc(16'hfff8, 1'b0);
    chk(seen[2:1], 2'b00);
  endtask : t_window

  task automatic t_modes;
    reboot(2'b01);
    wr(A_MODE, 8'h00);
    rdc(A_MODE, 32'h81);
    chk({rom, adv, expa}, 3'b001);
    reboot(2'b10);
    rdc(A_MODE, 32'h02);
    chk({rom, adv, expa, aok}, 4'b1101);
    wr(A_MODE, 8'h80);
    chk(aok, 1'b0);
    wr(A_SYS, 8'h41);
    chk(aok, 1'b1);
  endtask : t_modes

  // Watchdog then standby reload, both from altered contents
  task automatic t_reload;
    wr(A_BUS, 8'h00);
    @(posedge aclk);
    wdt <= 1'b1;
    @(posedge aclk);
    wdt <= 1'b0;
    rdc(A_SYS, 32'h01);
    rdc(A_MODE, 32'h02);
    rdc(A_BUS, 32'hd7);
    wr(A_BUS, 8'h00);
    chk(bcq, 8'h00);
    @(posedge aclk);
    hw_standby_n <= 1'b0;
    repeat (4) @(posedge aclk);
    hw_standby_n <= 1'b1;
    repeat (3) @(posedge aclk);
    rdc(A_BUS, 32'hd7);
    rdc(A_SYS, 32'h09);
  endtask : t_reload

  ////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and main sequence
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      results;
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {wdt, acc_req, acc_ext, hw_standby_n, mode_req} = 6'h7;
    {awaddr, wdata, araddr, acc_addr} = '0;
    wstrb = 4'h1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_vals;
    t_sys;
    t_strobe;
    t_window;
    t_modes;
    t_reload;
    results;
  end
endmodule : mcu_mode_and_system_control_tb
